// ===== pkg/wbr_map.vh
`ifndef WBR_MAP_VH
`define WBR_MAP_VH
// Command codes seen on the link
`define WBR_CMD_SETWRAP 8'h77
`define WBR_CMD_WORDRD 8'hE7
`define WBR_CMD_ENQPI 8'h38
`define WBR_CMD_PARAM 8'hC0
`define WBR_CMD_BURST 8'h0C
`define WBR_CMD_EXQPI 8'hFF
// Serial clock counts per phase
`define WBR_SPI_CMD_CLKS 6'h08
`define WBR_QPI_CMD_CLKS 6'h02
`define WBR_ADDR_CLKS 6'h06
`define WBR_WCFG_CLKS 6'h20
`define WBR_PARAM_CLKS 6'h02
`define WBR_WORDRD_TURN_CLKS 4'h4
// Dummy clock counts selected by the dummy count field
`define WBR_DUM_00 4'hA
`define WBR_DUM_01 4'h4
`define WBR_DUM_10 4'h6
`define WBR_DUM_11 4'h8
`define WBR_DUM_DTR 4'h8
// Field positions in the wrap byte and the parameter byte
`define WBR_WRAP_DIS_POS 4
`define WBR_WRAP_LEN_HI 6
`define WBR_WRAP_LEN_LO 5
`define WBR_PAR_DUM_HI 5
`define WBR_PAR_DUM_LO 4
`define WBR_PAR_WRAP_HI 1
`define WBR_PAR_WRAP_LO 0
// Reset values
`define WBR_WRAP_DIS_RST 1'b1
`define WBR_WRAP_LEN_RST 2'h0
`define WBR_DUM_FIELD_RST 2'h0
`define WBR_QWRAP_RST 2'h0
`endif

// ===== rtl/wbr_buf2.v
`timescale 1ns/1ns
`default_nettype none
// Two-entry buffer between the array fetch and the nibble shifter
module wbr_buf2 (
  // Clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  input wire flush_i,
  // Filling side
  input wire in_valid_i,
  input wire [7:0] in_data_i,
  output reg in_ready_o,
  // Draining side
  output wire out_valid_o,
  output wire [7:0] out_data_o,
  input wire out_ready_i
);
  reg [7:0] mem_q [0:1]; // Storage for two bytes
  reg wp_q; // Write slot
  reg rp_q; // Read slot
  reg [1:0] cnt_q; // Entries held
  wire push = in_valid_i & in_ready_o;
  wire pop = out_ready_i & out_valid_o;
  wire [1:0] cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o = mem_q[rp_q];

  // Ready is a flop so the far side sees a clean level
  always @(posedge mclk_i) begin
    if (!rst_n_i || flush_i) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
      in_ready_o <= 1'b1;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data_i;
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_d;
      in_ready_o <= (cnt_d != 2'h2);
    end
  end
endmodule
`default_nettype wire

// ===== rtl/wbr_core.v
`timescale 1ns/1ns
`default_nettype none
`include "wbr_map.vh"
// Notes on behaviour
// [R1] Wrap setting governs all later word reads
// [R2] Wrap confines data to aligned section
// [R3] Output starts at address, wraps until deselect
// [R4] Disable bit switches wrap, length bits size
// [R5] Wrap disabled by default; rewrite exits
// [R6] Host sends command, 24 dummy, wrap byte
// [R7] Parameter command sets dummy and wrap length
// [R8] Parameter command ignored in standard mode
// [R9] Wrap length carried into four-line mode
// [R10] Dummy programmable only in four-line mode
// [R11] Host reprograms dummy after entering four-line
// [R12] Fast read dummy codes: 10,4,6,8
// [R13] Burst wrap codes: 8,16,32,64 bytes
// [R14] Double-rate dummy codes: 10,8,8,8
// [R15] Burst read wraps like fast read
// [R16] Enter four-line mode only with quad enable
// [R17] Burst: 2 command, 6 address, dummy, data
// [R18] Drive data lines from dummy end to deselect
module wbr_core (
  // Clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // Flash pins
  input wire sclk_i,
  input wire cs_n_i,
  input wire [3:0] io_i,
  output reg [3:0] io_o,
  output reg [3:0] io_oe_o,
  // Configuration
  input wire quad_enable_i,
  // Status
  output reg qpi_mode_o,
  output reg wrap_disable_o,
  output reg [1:0] wrap_length_o,
  output reg [1:0] dummy_count_o,
  output reg [1:0] qpi_wrap_length_o,
  output reg [3:0] qpi_dummy_clks_o,
  output reg [3:0] qpi_dtr_dummy_clks_o,
  // Array read stream
  output reg [23:0] rd_addr_o,
  output reg rd_fetch_o,
  input wire [7:0] rd_data_i,
  input wire rd_valid_i,
  output wire rd_ready_o
);
  // Frame states
  localparam ST_CMD = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_WCFG = 3'h2;
  localparam ST_PARAM = 3'h3;
  localparam ST_DUMMY = 3'h4;
  localparam ST_DATA = 3'h5;
  localparam ST_IGN = 3'h6;

  // Pin synchronisers, second stage feeds all logic
  reg [1:0] sclk_s_q;
  reg [1:0] cs_s_q;
  reg [3:0] io_s1_q;
  reg [3:0] io_s2_q;
  reg sclk_d_q; // Previous synced clock level

  reg [2:0] st_q; // Frame state
  reg [5:0] cnt_q; // Clocks in current phase
  reg [31:0] sh_q; // Shift register for command, address, config
  reg burst_q; // Current read is the four-line burst read
  reg [3:0] dum_tgt_q; // Dummy clocks for current read
  reg hi_q; // Next falling edge starts a new byte
  reg [3:0] lo_q; // Low nibble waiting to go out

  wire sclk_rise = sclk_s_q[1] & ~sclk_d_q;
  wire sclk_fall = ~sclk_s_q[1] & sclk_d_q;
  wire deselect = cs_s_q[1];
  wire [3:0] io_in = io_s2_q;

  // Next shift value, one line or four lines per clock
  wire quad_phase = qpi_mode_o | (st_q == ST_ADDR);
  wire [31:0] sh_d = quad_phase ? {sh_q[27:0], io_in} : {sh_q[30:0], io_in[0]};
  wire [5:0] cnt_d = cnt_q + 6'h01;
  wire [5:0] cmd_clks = qpi_mode_o ? `WBR_QPI_CMD_CLKS : `WBR_SPI_CMD_CLKS; // [R17]

  // Buffer drain side
  wire buf_valid;
  wire [7:0] buf_data;
  wire pop = sclk_fall & (st_q == ST_DATA) & hi_q & buf_valid;

  // Dummy clock table for four-line reads
  function [3:0] dum_clks;
    input [1:0] field;
    input dtr;
    begin
      case (field)
        2'h0: dum_clks = `WBR_DUM_00; // [R12] [R14]
        2'h1: dum_clks = dtr ? `WBR_DUM_DTR : `WBR_DUM_01; // [R12] [R14]
        2'h2: dum_clks = dtr ? `WBR_DUM_DTR : `WBR_DUM_10; // [R12] [R14]
        default: dum_clks = dtr ? `WBR_DUM_DTR : `WBR_DUM_11; // [R12] [R14]
      endcase
    end
  endfunction

  // Section mask: burst uses the four-line field, word read the wrap bits
  reg [7:0] wmask;
  wire [1:0] wsel = burst_q ? qpi_wrap_length_o : wrap_length_o; // [R13] [R4]
  wire wrap_on = burst_q | ~wrap_disable_o; // [R1] [R15]
  always @* begin
    case (wsel)
      2'h0: wmask = 8'h07; // [R13] 8 bytes
      2'h1: wmask = 8'h0F; // [R13] 16 bytes
      2'h2: wmask = 8'h1F; // [R13] 32 bytes
      default: wmask = 8'h3F; // [R13] 64 bytes
    endcase
  end

  // Next array address; inside the page the low bits roll within the section
  wire [7:0] lo_inc = rd_addr_o[7:0] + 8'h01;
  wire [23:0] addr_wrap = {rd_addr_o[23:8], (rd_addr_o[7:0] & ~wmask) | (lo_inc & wmask)}; // [R2]
  wire [23:0] addr_next = wrap_on ? addr_wrap : rd_addr_o + 24'h000001; // [R3]

  // Synchronise pins; only the second stage is looked at
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sclk_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
      sclk_d_q <= 1'b0;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk_i};
      cs_s_q <= {cs_s_q[0], cs_n_i};
      io_s1_q <= io_i;
      io_s2_q <= io_s1_q;
      sclk_d_q <= sclk_s_q[1];
    end
  end

  // Frame sequencer and settings
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q <= ST_CMD;
      cnt_q <= 6'h00;
      sh_q <= 32'h00000000;
      burst_q <= 1'b0;
      dum_tgt_q <= 4'h0;
      hi_q <= 1'b1;
      lo_q <= 4'h0;
      io_o <= 4'h0;
      io_oe_o <= 4'h0;
      rd_addr_o <= 24'h000000;
      rd_fetch_o <= 1'b0;
      qpi_mode_o <= 1'b0;
      wrap_disable_o <= `WBR_WRAP_DIS_RST; // [R5] no wrap after reset
      wrap_length_o <= `WBR_WRAP_LEN_RST;
      dummy_count_o <= `WBR_DUM_FIELD_RST;
      qpi_wrap_length_o <= `WBR_QWRAP_RST;
      qpi_dummy_clks_o <= `WBR_DUM_00;
      qpi_dtr_dummy_clks_o <= `WBR_DUM_00;
    end else if (deselect) begin
      // Select high ends any read and frees the lines
      st_q <= ST_CMD;
      cnt_q <= 6'h00;
      hi_q <= 1'b1;
      io_oe_o <= 4'h0; // [R18]
      rd_fetch_o <= 1'b0; // [R3]
    end else begin
      // Advance the fetch address on each byte taken by the buffer
      if (rd_fetch_o && rd_valid_i && rd_ready_o) begin
        rd_addr_o <= addr_next; // [R3]
      end
      if (sclk_rise) begin
        case (st_q)
          ST_CMD: begin
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            if (cnt_d == cmd_clks) begin
              cnt_q <= 6'h00;
              st_q <= ST_IGN;
              if (qpi_mode_o) begin
                if (sh_d[7:0] == `WBR_CMD_BURST) begin
                  st_q <= ST_ADDR; // [R15] [R17]
                  burst_q <= 1'b1;
                end else if (sh_d[7:0] == `WBR_CMD_PARAM) begin
                  st_q <= ST_PARAM; // [R7]
                end else if (sh_d[7:0] == `WBR_CMD_EXQPI) begin
                  qpi_mode_o <= 1'b0; // Wrap settings are left as they are
                end
              end else begin
                // The parameter command has no branch here and falls to ignore
                if (sh_d[7:0] == `WBR_CMD_SETWRAP) begin
                  st_q <= ST_WCFG; // [R6] [R8]
                end else if (sh_d[7:0] == `WBR_CMD_WORDRD && quad_enable_i) begin
                  st_q <= ST_ADDR; // [R1]
                  burst_q <= 1'b0;
                end else if (sh_d[7:0] == `WBR_CMD_ENQPI && quad_enable_i) begin
                  qpi_mode_o <= 1'b1; // [R16]
                  qpi_wrap_length_o <= wrap_length_o; // [R9]
                end
              end
            end
          end
          ST_ADDR: begin
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            if (cnt_d == `WBR_ADDR_CLKS) begin
              // Address complete: start fetching and count dummies
              cnt_q <= 6'h00;
              rd_addr_o <= sh_d[23:0]; // [R3]
              rd_fetch_o <= 1'b1;
              st_q <= ST_DUMMY;
              dum_tgt_q <= burst_q ? qpi_dummy_clks_o : `WBR_WORDRD_TURN_CLKS; // [R10] [R11]
            end
          end
          ST_WCFG: begin
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            if (cnt_d == `WBR_WCFG_CLKS) begin
              // Wrap byte is the last eight bits after 24 dummy bits
              wrap_disable_o <= sh_d[`WBR_WRAP_DIS_POS]; // [R4] [R5] [R1]
              wrap_length_o <= sh_d[`WBR_WRAP_LEN_HI:`WBR_WRAP_LEN_LO]; // [R4] [R6]
              st_q <= ST_IGN;
            end
          end
          ST_PARAM: begin
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            if (cnt_d == `WBR_PARAM_CLKS) begin
              dummy_count_o <= sh_d[`WBR_PAR_DUM_HI:`WBR_PAR_DUM_LO]; // [R7] [R10]
              qpi_wrap_length_o <= sh_d[`WBR_PAR_WRAP_HI:`WBR_PAR_WRAP_LO]; // [R7]
              qpi_dummy_clks_o <= dum_clks(sh_d[`WBR_PAR_DUM_HI:`WBR_PAR_DUM_LO], 1'b0); // [R12]
              qpi_dtr_dummy_clks_o <= dum_clks(sh_d[`WBR_PAR_DUM_HI:`WBR_PAR_DUM_LO],
                1'b1); // [R14]
              st_q <= ST_IGN;
            end
          end
          ST_DUMMY: begin
            cnt_q <= cnt_d;
            if (cnt_d == {2'h0, dum_tgt_q}) begin
              st_q <= ST_DATA; // [R17]
              hi_q <= 1'b1;
            end
          end
          default: begin
            // Data and ignored frames wait for deselect
            cnt_q <= cnt_q;
          end
        endcase
      end
      // Data goes out on falling edges, high nibble first
      if (sclk_fall && st_q == ST_DATA) begin
        io_oe_o <= 4'hF; // [R18]
        hi_q <= ~hi_q;
        if (hi_q) begin
          // An empty buffer repeats the last nibble rather than stall the link
          if (buf_valid) begin
            io_o <= buf_data[7:4]; // [R17]
            lo_q <= buf_data[3:0];
          end
        end else begin
          io_o <= lo_q;
        end
      end
    end
  end

  // Prefetch buffer; flushed at deselect so stale bytes never leak
  wbr_buf2 u_buf (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .flush_i(deselect),
    .in_valid_i(rd_valid_i & rd_fetch_o),
    .in_data_i(rd_data_i),
    .in_ready_o(rd_ready_o),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(pop)
  );
endmodule
`default_nettype wire

// ===== tb/wbr_core_sva.sv
`timescale 1ns/1ns
`default_nettype none
module wbr_core_sva (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Pins and setting
  input wire logic cs_n_i,
  input wire logic quad_enable_i,
  input wire logic [3:0] io_oe_o,
  // Status
  input wire logic qpi_mode_o,
  input wire logic wrap_disable_o,
  input wire logic [1:0] wrap_length_o,
  input wire logic [1:0] dummy_count_o,
  input wire logic [1:0] qpi_wrap_length_o,
  input wire logic [3:0] qpi_dummy_clks_o,
  input wire logic [3:0] qpi_dtr_dummy_clks_o,
  // Array stream
  input wire logic [23:0] rd_addr_o,
  input wire logic rd_fetch_o,
  input wire logic rd_valid_i,
  input wire logic rd_ready_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Section size in use; four-line bursts always wrap
  wire [1:0] wsel = qpi_mode_o ? qpi_wrap_length_o : wrap_length_o;
  wire wrp = qpi_mode_o || !wrap_disable_o;
  wire [23:0] msk = wrp ? ((24'h8 << wsel) - 24'h1) : 24'hFFFFFF;
  // Next byte address: offset steps inside the section only
  wire [23:0] nxt = (rd_addr_o & ~msk) | ((rd_addr_o + 24'h1) & msk);
  // Deselect held long enough for the frame to be torn down
  sequence s_idle;
    cs_n_i [*6];
  endsequence
  a_reset_values:
    assert property ($rose(rst_n_i) |-> wrap_disable_o && !qpi_mode_o && io_oe_o == 4'h0)
    else $error("Reset state wrong");
  a_dummy_map:
    assert property ($stable(dummy_count_o) |-> qpi_dummy_clks_o ==
      (dummy_count_o == 2'h0 ? 4'hA : {1'b0, dummy_count_o, 1'b0} + 4'h2))
    else $error("Dummy count wrong");
  a_dtr_map:
    assert property ($stable(dummy_count_o) |->
      qpi_dtr_dummy_clks_o == (dummy_count_o == 2'h0 ? 4'hA : 4'h8))
    else $error("Double-rate dummy count wrong");
  a_oe_idle:
    assert property (s_idle |-> io_oe_o == 4'h0)
    else $error("Lines driven while deselected");
  // A byte offered in the cycle the synced deselect lands is flushed, not taken
  a_addr_step:
    assert property (rd_fetch_o && rd_valid_i && rd_ready_o && !$past(cs_n_i, 2) |=>
      rd_addr_o == $past(nxt))
    else $error("Byte address step wrong");
  a_entry_needs_enable:
    assert property ($rose(qpi_mode_o) |-> $past(quad_enable_i))
    else $error("Four-line mode without quad enable");
  a_param_spi:
    assert property (!qpi_mode_o && !$past(qpi_mode_o) |-> $stable(dummy_count_o))
    else $error("Dummy field changed in standard mode");
  a_wrap_kept:
    assert property ($rose(qpi_mode_o) |-> ##[0:1] qpi_wrap_length_o == wrap_length_o)
    else $error("Wrap length lost on mode entry");
endmodule
bind wbr_core wbr_core_sva u_sva (.*);
`default_nettype wire

// ===== tb/wbr_host.sv
`timescale 1ns/1ns
`default_nettype none
module wbr_host (
  // Clock
  input wire logic mclk_i,
  // Link pins
  input wire logic [3:0] pin_i,
  output var logic sclk_o,
  output var logic cs_n_o,
  output var logic [3:0] io_o
);
  logic [7:0] got [0:31]; // Bytes read back
  logic [3:0] hi; // Upper nibble seen
  logic [3:0] lo; // Lower nibble seen
  integer k; // Loop index
  // Idle link: deselected, clock parked low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
  end
  // One serial clock; the pin is read late in the low phase, once settled
  task tick(input [3:0] v, output [3:0] r);
    @(posedge mclk_i) io_o <= v;
    repeat (4) @(posedge mclk_i);
    r = pin_i;
    sclk_o <= 1'b1;
    repeat (5) @(posedge mclk_i);
    sclk_o <= 1'b0;
  endtask
  // Byte on the first line, one bit a clock, top bit first
  task sb(input [7:0] b);
    for (k = 7; k >= 0; k = k - 1) tick({3'h0, b[k]}, hi);
  endtask
  // Byte on all four lines, high nibble first
  task qb(input [7:0] b);
    tick(b[7:4], hi);
    tick(b[3:0], hi);
  endtask
  task qa(input [23:0] a);
    qb(a[23:16]);
    qb(a[15:8]);
    qb(a[7:0]);
  endtask
  task dum(input integer n);
    repeat (n) tick(4'h0, hi);
  endtask
  // Lines are let go, so they toggle rather than hold a stale level
  task rd(input integer n);
    for (k = 0; k < n; k = k + 1) begin
      tick(~io_o, hi);
      tick(~io_o, lo);
      got[k] = {hi, lo};
    end
  endtask
  task open;
    @(posedge mclk_i) cs_n_o <= 1'b0;
  endtask
  // Gap kept well past the minimum between frames
  task close;
    @(posedge mclk_i) cs_n_o <= 1'b1;
    repeat (6) @(posedge mclk_i);
  endtask
endmodule
`default_nettype wire

// ===== tb/wbr_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module wbr_core_tb;
  logic mclk_i; // System clock
  logic rst_n_i; // Reset, active low
  logic quad_en; // Quad enable setting
  integer fails; // Mismatches
  integer compares; // Checks made
  integer i; // Loop index
  wire sclk, cs_n, four_line_command_mode, wdis, fetch, rdy;
  wire [3:0] h_io, io, oe, qdum, ddum;
  wire [1:0] wl, dfield, qwl;
  wire [23:0] addr;
  // The device wins the wire where it enables its drivers
  wire [3:0] pin = (oe & io) | (~oe & h_io);
  wbr_host host (.mclk_i(mclk_i), .pin_i(pin), .sclk_o(sclk), .cs_n_o(cs_n), .io_o(h_io));
  // Array content is the low address byte, ready whenever fetched
  wbr_core dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .io_i(pin), .io_o(io), .io_oe_o(oe), .quad_enable_i(quad_en), .qpi_mode_o(four_line_command_mode),
    .wrap_disable_o(wdis), .wrap_length_o(wl), .dummy_count_o(dfield),
    .qpi_wrap_length_o(qwl), .qpi_dummy_clks_o(qdum), .qpi_dtr_dummy_clks_o(ddum),
    .rd_addr_o(addr), .rd_fetch_o(fetch), .rd_data_i(addr[7:0]), .rd_valid_i(fetch),
    .rd_ready_o(rdy));
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task give_verdict;
    $display("Counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task set_wrap(input [7:0] w);
    host.open();
    host.sb(8'h77);
    repeat (3) host.sb(8'h00);
    host.sb(w);
    host.close();
  endtask
  // Read frame: command, address, turnaround, n bytes
  task qread(input q, input [7:0] c, input [23:0] a, input integer nd, input integer n);
    host.open();
    if (q) host.qb(c);
    else host.sb(c);
    host.qa(a);
    host.dum(nd);
    host.rd(n);
    host.close();
  endtask
  // Command with an optional argument byte
  task cmd(input q, input [7:0] c, input [7:0] p, input np);
    host.open();
    if (q) host.qb(c);
    else host.sb(c);
    if (np && q) host.qb(p);
    if (np && !q) host.sb(p);
    host.close();
  endtask
  initial begin
    rst_n_i = 1'b0;
    quad_en = 1'b1;
    fails = 0;
    compares = 0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk(wdis, 1'b1);
    chk(qdum, 4'hA);
    set_wrap(8'h20);
    chk(wdis, 1'b0);
    chk(wl, 2'h1);
    qread(1'b0, 8'hE7, 24'h00001C, 4, 20);
    for (i = 0; i < 20; i = i + 1) chk(host.got[i], 8'h10 | ((i + 12) % 16));
    set_wrap(8'h50);
    chk(wdis, 1'b1);
    qread(1'b0, 8'hE7, 24'h0000FE, 4, 4);
    for (i = 0; i < 4; i = i + 1) chk(host.got[i], (254 + i) % 256);
    $display("Word read tests done");
    cmd(1'b0, 8'hC0, 8'h30, 1'b1);
    chk(dfield, 2'h0);
    quad_en <= 1'b0;
    cmd(1'b0, 8'h38, 8'h00, 1'b0);
    chk(four_line_command_mode, 1'b0);
    quad_en <= 1'b1;
    cmd(1'b0, 8'h38, 8'h00, 1'b0);
    chk(four_line_command_mode, 1'b1);
    chk(qwl, 2'h2);
    $display("Mode tests done");
    for (i = 0; i < 4; i = i + 1) begin
      cmd(1'b1, 8'hC0, 8'(15 * i + 3), 1'b1);
      chk(dfield, i);
      chk(qdum, i == 0 ? 10 : 2 + 2 * i);
      chk(ddum, i == 0 ? 10 : 8);
      chk(qwl, 3 - i);
    end
    cmd(1'b1, 8'hC0, 8'h10, 1'b1);
    qread(1'b1, 8'h0C, 24'h000105, 4, 12);
    for (i = 0; i < 12; i = i + 1) chk(host.got[i], (5 + i) % 8);
    cmd(1'b1, 8'hFF, 8'h00, 1'b0);
    chk(four_line_command_mode, 1'b0);
    $display("Burst tests done");
    give_verdict();
  end
  // Run should end near 21 us; a hang is cut well beyond that
  initial begin
    #400000;
    fails = fails + 1;
    give_verdict();
  end
endmodule
`default_nettype wire
